// *** src/incsp_dev.sv ***
/*
  Device end of the inclinometer serial port: samples the host's pins,
  decodes 16-bit frames, passes write commands out through a FIFO and
  returns register contents requested in the previous frame.
  Assumes the register store sits outside and answers rd_addr with
  rd_data combinationally in the same clock.
*/
`timescale 1ns/1ns
`include "incsp_consts.svh"

module incsp_dev (
  input wire logic core_clk,
  input wire logic nrst,
  incsp_link_if.dev link,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [`INCSP_ADDR_W-1:0] wr_addr,
  output logic [`INCSP_DATA_W-1:0] wr_data,
  output logic [`INCSP_ADDR_W-1:0] rd_addr,
  input wire logic [`INCSP_REG_W-1:0] rd_data,
  output logic frame_err
);
  logic cs_m_reg;
  logic cs_s_reg;
  logic cs_d_reg;
  logic ck_m_reg;
  logic ck_s_reg;
  logic ck_d_reg;
  logic di_m_reg;
  logic di_s_reg;
  logic [`INCSP_CNT_W-1:0] cnt_reg;
  logic [`INCSP_REG_W-1:0] rx_reg;
  logic [`INCSP_REG_W-1:0] tx_reg;
  logic [`INCSP_ADDR_W-1:0] rd_addr_reg;
  logic sdo_reg;
  logic oe_reg;
  logic err_reg;
  logic drop_reg;
  logic push_reg;
  logic [`INCSP_REG_W-1:0] push_word_reg;

  // Edge events; clock edges only meaningful while selected
  wire cs_fall = cs_d_reg && !cs_s_reg;
  wire cs_rise = !cs_d_reg && cs_s_reg;
  wire selected = !cs_s_reg;
  wire ck_rise = selected && ck_s_reg && !ck_d_reg;
  wire ck_fall = selected && !ck_s_reg && ck_d_reg;
  wire [`INCSP_REG_W-1:0] rx_next = {rx_reg[`INCSP_REG_W-2:0], di_s_reg};
  wire last_bit = ck_rise && (cnt_reg == 5'(`INCSP_FRAME_BITS - 1));
  wire is_write = rx_next[`INCSP_WR_BIT] && !rx_next[`INCSP_ZERO_BIT];
  wire is_read = !rx_next[`INCSP_WR_BIT] && !rx_next[`INCSP_ZERO_BIT];
  wire fifo_full_n;
  // Write lost to a full FIFO
  wire wr_drop = push_reg && !fifo_full_n;
  logic [`INCSP_REG_W-1:0] fifo_out;

  // Two flops on every pin before use
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_m_reg <= 1'b1;
      cs_s_reg <= 1'b1;
      cs_d_reg <= 1'b1;
      ck_m_reg <= 1'b1;
      ck_s_reg <= 1'b1;
      ck_d_reg <= 1'b1;
      di_m_reg <= 1'b0;
      di_s_reg <= 1'b0;
    end
    else
    begin
      cs_m_reg <= link.cs_n;
      cs_s_reg <= cs_m_reg;
      cs_d_reg <= cs_s_reg;
      ck_m_reg <= link.sclk;
      ck_s_reg <= ck_m_reg;
      ck_d_reg <= ck_s_reg;
      di_m_reg <= link.sdi;
      di_s_reg <= di_m_reg;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= '0;
      rx_reg <= '0;
      tx_reg <= '0;
    end
    else if (cs_fall)
    begin
      cnt_reg <= '0;
      rx_reg <= '0;
      // Fetched at select, so a read answers in the next frame
      tx_reg <= {rd_data[`INCSP_REG_W-2:0], 1'b0};
    end
    else if (ck_rise)
    begin
      rx_reg <= rx_next;
      cnt_reg <= cnt_reg + 1'b1;
    end
    else if (ck_fall && cnt_reg != '0)
      tx_reg <= {tx_reg[`INCSP_REG_W-2:0], 1'b0};
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else if (cs_fall)
    begin
      sdo_reg <= rd_data[`INCSP_REG_W-1];
      oe_reg <= 1'b1;
    end
    else if (cs_rise)
      oe_reg <= 1'b0;
    else if (ck_fall && cnt_reg != '0)
      sdo_reg <= tx_reg[`INCSP_REG_W-1];
  end

  // latch read address for next frame
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_addr_reg <= '0;
      push_reg <= 1'b0;
      push_word_reg <= '0;
      err_reg <= 1'b0;
    end
    else
    begin
      push_reg <= 1'b0;
      if (last_bit && is_read)
        rd_addr_reg <= rx_next[`INCSP_ADDR_MSB:`INCSP_ADDR_LSB];
      if (last_bit && is_write)
      begin
        push_reg <= 1'b1;
        push_word_reg <= rx_next;
      end
      if (cs_rise)
        err_reg <= (cnt_reg != 5'(`INCSP_FRAME_BITS)) || drop_reg
                   || wr_drop;
      else if (wr_drop)
        err_reg <= 1'b1;
    end
  end

  // Overflow kept until frame end so it survives the length check
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      drop_reg <= 1'b0;
    else if (cs_fall)
      drop_reg <= 1'b0;
    else if (wr_drop)
      drop_reg <= 1'b1;
  end

  incsp_fifo #(
    .WIDTH(`INCSP_REG_W),
    .DEPTH(`INCSP_FIFO_DEPTH)
  ) u_wr_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(push_reg),
    .in_ready(fifo_full_n),
    .in_data(push_word_reg),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );

  assign wr_addr = fifo_out[`INCSP_ADDR_MSB:`INCSP_ADDR_LSB];
  assign wr_data = fifo_out[`INCSP_DATA_MSB:`INCSP_DATA_LSB];
  assign rd_addr = rd_addr_reg;
  assign frame_err = err_reg;
  assign link.sdo_out = sdo_reg;
  assign link.sdo_oe = oe_reg;
endmodule : incsp_dev

// *** src/incsp_consts.svh ***
/*
  Shared constants for the inclinometer serial port ends: frame length,
  command bit layout, timing figures and derived cycle counts.
  Assumes a core clock of 10 MHz on both ends.
*/
`ifndef INCSP_CONSTS_SVH
`define INCSP_CONSTS_SVH

`define INCSP_CLK_HZ 10000000
`define INCSP_FRAME_BITS 16
`define INCSP_CNT_W 5
`define INCSP_ADDR_W 6
`define INCSP_DATA_W 8
`define INCSP_WR_BIT 15
`define INCSP_ZERO_BIT 14
`define INCSP_ADDR_MSB 13
`define INCSP_ADDR_LSB 8
`define INCSP_DATA_MSB 7
`define INCSP_DATA_LSB 0
`define INCSP_SMPL_FAST_MAX 8'h07
`define INCSP_SCLK_FAST_KHZ 2500
`define INCSP_SCLK_NORM_KHZ 1000
`define INCSP_GAP_FAST_US 40
`define INCSP_GAP_NORM_US 100
// Half period rounded up so the link clock stays at or under the limit
`define INCSP_HALF_FAST_RATE ((`INCSP_CLK_HZ / 1000 \
  + 2 * `INCSP_SCLK_FAST_KHZ - 1) / (2 * `INCSP_SCLK_FAST_KHZ))
`define INCSP_HALF_NORM_RATE ((`INCSP_CLK_HZ / 1000 \
  + 2 * `INCSP_SCLK_NORM_KHZ - 1) / (2 * `INCSP_SCLK_NORM_KHZ))
// Data out needs six core cycles from a falling edge to reach the
// host's capture through both ends' synchronisers; slower is legal
`define INCSP_HALF_MIN 6
`define INCSP_HALF_FAST ((`INCSP_HALF_FAST_RATE > `INCSP_HALF_MIN) \
  ? `INCSP_HALF_FAST_RATE : `INCSP_HALF_MIN)
`define INCSP_HALF_NORM ((`INCSP_HALF_NORM_RATE > `INCSP_HALF_MIN) \
  ? `INCSP_HALF_NORM_RATE : `INCSP_HALF_MIN)
`define INCSP_GAP_FAST_CYC ((`INCSP_GAP_FAST_US \
  * (`INCSP_CLK_HZ / 1000) + 999) / 1000)
`define INCSP_GAP_NORM_CYC ((`INCSP_GAP_NORM_US \
  * (`INCSP_CLK_HZ / 1000) + 999) / 1000)
`define INCSP_CS_LEAD_CYC 1
`define INCSP_FIFO_DEPTH 4
`define INCSP_REG_W 16

`endif

// *** src/incsp_pkg.sv ***
/*
  Types shared by the inclinometer serial port ends.
  Assumes incsp_consts.svh is on the include path.
*/
`include "incsp_consts.svh"

package incsp_pkg;

  typedef logic [`INCSP_REG_W-1:0] incsp_word_type;

  typedef enum logic [2:0] {
    INCSP_H_IDLE = 3'b000,
    INCSP_H_LEAD = 3'b001,
    INCSP_H_LOW = 3'b010,
    INCSP_H_HIGH = 3'b011,
    INCSP_H_TAIL = 3'b100,
    INCSP_H_GAP = 3'b101
  } incsp_host_state_type;

endpackage : incsp_pkg

// *** src/incsp_link_if.sv ***
/*
  Four-wire serial link between the inclinometer port and its host.
  Data output is resolved here from the device's enable; a released
  line shows the high level of its assumed pull-up.
*/
`timescale 1ns/1ns

interface incsp_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo_out;
  logic sdo_oe;
  wire sdo;

  assign sdo = sdo_oe ? sdo_out : 1'b1;

  modport dev (
    input cs_n,
    input sclk,
    input sdi,
    output sdo_out,
    output sdo_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output sdi,
    input sdo
  );
endinterface : incsp_link_if

// *** src/incsp_fifo.sv ***
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock domain; depth is a power of two.
*/
`timescale 1ns/1ns

module incsp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] wr_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_reg] <= in_data;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_reg <= '0;
      wr_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : incsp_fifo

// *** src/incsp_host.sv ***
/*
  Host end of the inclinometer serial port: runs one 16-bit frame per
  request, deriving the serial clock by division from the core clock,
  and reports the word received during the frame.
  Assumes requests are held until taken.
*/
`timescale 1ns/1ns
`include "incsp_consts.svh"

module incsp_host (
  input wire logic core_clk,
  input wire logic nrst,
  incsp_link_if.host link,
  input wire logic [7:0] sample_time_setting,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [`INCSP_REG_W-1:0] req_word,
  output logic rsp_valid,
  output logic [`INCSP_REG_W-1:0] rsp_word
);
  incsp_pkg::incsp_host_state_type st_reg;
  logic [7:0] tmr_reg;
  logic [`INCSP_CNT_W-1:0] cnt_reg;
  logic [`INCSP_REG_W-1:0] tx_reg;
  logic [`INCSP_REG_W-1:0] rx_reg;
  logic [`INCSP_REG_W-1:0] rsp_reg;
  logic rsp_v_reg;
  logic cs_reg;
  logic ck_reg;
  logic sdo_m_reg;
  logic sdo_s_reg;
  logic [7:0] half_reg;
  logic [11:0] gap_reg;
  logic [11:0] gap_cnt_reg;

  wire fast = (sample_time_setting <= `INCSP_SMPL_FAST_MAX);
  wire tmr_done = (tmr_reg == 8'h01);
  wire last = (cnt_reg == 5'(`INCSP_FRAME_BITS - 1));

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sdo_m_reg <= 1'b0;
      sdo_s_reg <= 1'b0;
    end
    else
    begin
      sdo_m_reg <= link.sdo;
      sdo_s_reg <= sdo_m_reg;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= incsp_pkg::INCSP_H_IDLE;
      tmr_reg <= 8'h00;
      cnt_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      rsp_reg <= '0;
      rsp_v_reg <= 1'b0;
      cs_reg <= 1'b1;
      ck_reg <= 1'b1;
      half_reg <= 8'h01;
      gap_reg <= 12'h001;
      gap_cnt_reg <= 12'h000;
    end
    else
    begin
      rsp_v_reg <= 1'b0;
      if (gap_cnt_reg != 12'h000)
        gap_cnt_reg <= gap_cnt_reg - 12'h001;
      case (st_reg)
        incsp_pkg::INCSP_H_IDLE:
        begin
          if (req_valid && gap_cnt_reg == 12'h000)
          begin
            half_reg <= fast ? 8'(`INCSP_HALF_FAST) : 8'(`INCSP_HALF_NORM);
            gap_reg <= fast ? 12'(`INCSP_GAP_FAST_CYC)
                            : 12'(`INCSP_GAP_NORM_CYC);
            gap_cnt_reg <= fast ? 12'(`INCSP_GAP_FAST_CYC)
                                : 12'(`INCSP_GAP_NORM_CYC);
            tx_reg <= req_word;
            cnt_reg <= '0;
            cs_reg <= 1'b0;
            tmr_reg <= fast ? 8'(`INCSP_HALF_FAST) : 8'(`INCSP_HALF_NORM);
            st_reg <= incsp_pkg::INCSP_H_LEAD;
          end
        end
        incsp_pkg::INCSP_H_LEAD:
        begin
          tmr_reg <= tmr_reg - 8'h01;
          if (tmr_done)
          begin
            ck_reg <= 1'b0;
            tmr_reg <= half_reg;
            st_reg <= incsp_pkg::INCSP_H_LOW;
          end
        end
        incsp_pkg::INCSP_H_LOW:
        begin
          tmr_reg <= tmr_reg - 8'h01;
          if (tmr_done)
          begin
            ck_reg <= 1'b1;
            rx_reg <= {rx_reg[`INCSP_REG_W-2:0], sdo_s_reg};
            tmr_reg <= half_reg;
            st_reg <= incsp_pkg::INCSP_H_HIGH;
          end
        end
        incsp_pkg::INCSP_H_HIGH:
        begin
          tmr_reg <= tmr_reg - 8'h01;
          if (tmr_done)
          begin
            if (last)
              st_reg <= incsp_pkg::INCSP_H_TAIL;
            else
            begin
              ck_reg <= 1'b0;
              tx_reg <= {tx_reg[`INCSP_REG_W-2:0], 1'b0};
              cnt_reg <= cnt_reg + 1'b1;
              st_reg <= incsp_pkg::INCSP_H_LOW;
            end
            tmr_reg <= half_reg;
          end
        end
        incsp_pkg::INCSP_H_TAIL:
        begin
          tmr_reg <= tmr_reg - 8'h01;
          if (tmr_done)
          begin
            cs_reg <= 1'b1;
            rsp_reg <= rx_reg;
            rsp_v_reg <= 1'b1;
            st_reg <= incsp_pkg::INCSP_H_GAP;
          end
        end
        incsp_pkg::INCSP_H_GAP:
          st_reg <= incsp_pkg::INCSP_H_IDLE;
        default:
          st_reg <= incsp_pkg::INCSP_H_IDLE;
      endcase
    end
  end

  assign req_ready = (st_reg == incsp_pkg::INCSP_H_IDLE)
                     && (gap_cnt_reg == 12'h000);
  assign rsp_valid = rsp_v_reg;
  assign rsp_word = rsp_reg;
  assign link.cs_n = cs_reg;
  assign link.sclk = ck_reg;
  assign link.sdi = tx_reg[`INCSP_REG_W-1];
endmodule : incsp_host

// *** dv/incsp_checker.sv ***
/*
  Link checker for the inclinometer serial port.
  Assumes both ends on one core clock, link signals given as inputs.
*/
`timescale 1ns/1ns

module incsp_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe
);
  localparam int GAP_MIN = 400;
  logic sclk_q_reg;
  logic cs_q_reg;
  logic [4:0] rise_cnt_reg;
  logic [9:0] gap_cnt_reg;
  wire cs_fall = cs_q_reg && !cs_n;
  wire sclk_rise = !cs_n && sclk && !sclk_q_reg;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_q_reg <= 1'b1;
      cs_q_reg <= 1'b1;
    end
    else
    begin
      sclk_q_reg <= sclk;
      cs_q_reg <= cs_n;
    end
  end

  // Count restarts at every frame start
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rise_cnt_reg <= 5'h00;
    else if (cs_fall)
      rise_cnt_reg <= 5'h00;
    else if (sclk_rise)
      rise_cnt_reg <= rise_cnt_reg + 5'h01;
  end

  // Saturates so an idle link never wraps into a false short gap
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      gap_cnt_reg <= 10'h3FF;
    else if (cs_fall)
      gap_cnt_reg <= 10'h001;
    else if (gap_cnt_reg != 10'h3FF)
      gap_cnt_reg <= gap_cnt_reg + 10'h001;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  property p_idle;
    cs_n && $past(cs_n) |-> sclk;
  endproperty
  a_idle: assert property (p_idle)
    else $error("link clock low while deselected");
  property p_lead;
    $fell(cs_n) |-> sclk ##1 sclk;
  endproperty
  a_lead: assert property (p_lead)
    else $error("clock edge too soon after select");
  property p_low;
    $fell(sclk) |=> !sclk;
  endproperty
  a_low: assert property (p_low)
    else $error("link clock low phase too short");
  property p_high;
    $rose(sclk) && !cs_n |=> sclk;
  endproperty
  a_high: assert property (p_high)
    else $error("link clock high phase too short");
  property p_sdi;
    !cs_n && $past(!cs_n) && sclk && sclk_q_reg |-> $stable(sdi);
  endproperty
  a_sdi: assert property (p_sdi)
    else $error("host data moved while clock high");
  property p_len;
    $rose(cs_n) |-> rise_cnt_reg == 5'h10;
  endproperty
  a_len: assert property (p_len)
    else $error("frame did not hold sixteen clocks");
  property p_gap;
    $fell(cs_n) |-> gap_cnt_reg >= GAP_MIN;
  endproperty
  a_gap: assert property (p_gap)
    else $error("frame starts too close");
  property p_first;
    $fell(cs_n) |-> ##[1:5] sdo_oe;
  endproperty
  a_first: assert property (p_first)
    else $error("first output bit not driven");
  property p_release;
    cs_n [*6] |-> !sdo_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("output still driven after deselect");

  c_frame: cover property ($rose(cs_n) && rise_cnt_reg == 5'h10);
  c_drive0: cover property (sdo_oe && !sdo_out);
  c_spaced: cover property ($fell(cs_n) && gap_cnt_reg != 10'h3FF);
endmodule : incsp_checker

// *** dv/inclinometer_spi_slave_port_tb.sv ***
/*
  Bench for both serial port ends joined by one link, plus a second
  device end driven by hand for malformed frames.
  Assumes a 10 MHz core clock and a pull-up on the data output.
*/
`timescale 1ns/1ns

module inclinometer_spi_slave_port_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sts = 8'h07;
  logic [7:0] last_sts = 8'h00;
  logic req_valid = 1'b0;
  logic wr_ready = 1'b0;
  logic req_ready, rsp_valid, wr_valid, frame_err, wr_valid_b, frame_err_b;
  logic [5:0] wr_addr, rd_addr, wr_addr_b;
  logic [7:0] wr_data, wr_data_b;
  incsp_pkg::incsp_word_type req_word = 16'h0000;
  incsp_pkg::incsp_word_type rsp_word, rd_data;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int last_fall = -1;

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  function automatic incsp_pkg::incsp_word_type reg_val(input logic [5:0] a);
    reg_val = {a, 2'h2, ~a, 2'h1};
  endfunction : reg_val
  assign rd_data = reg_val(rd_addr);

  incsp_link_if u_incsp_link_if ();
  incsp_link_if u_incsp_link_if_b ();

  incsp_dev u_incsp_dev (.core_clk(core_clk), .nrst(nrst),
    .link(u_incsp_link_if), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .frame_err(frame_err));
  incsp_dev u_incsp_dev_b (.core_clk(core_clk), .nrst(nrst),
    .link(u_incsp_link_if_b), .wr_valid(wr_valid_b), .wr_ready(1'b0),
    .wr_addr(wr_addr_b), .wr_data(wr_data_b), .rd_addr(),
    .rd_data(16'h0000), .frame_err(frame_err_b));
  incsp_host u_incsp_host (.core_clk(core_clk), .nrst(nrst),
    .link(u_incsp_link_if), .sample_time_setting(sts),
    .req_valid(req_valid), .req_ready(req_ready), .req_word(req_word),
    .rsp_valid(rsp_valid), .rsp_word(rsp_word));
  incsp_checker u_incsp_checker (.core_clk(core_clk), .nrst(nrst),
    .cs_n(u_incsp_link_if.cs_n), .sclk(u_incsp_link_if.sclk),
    .sdi(u_incsp_link_if.sdi), .sdo_out(u_incsp_link_if.sdo_out),
    .sdo_oe(u_incsp_link_if.sdo_oe));

  task automatic check(input string name, input incsp_pkg::incsp_word_type
    seen, input incsp_pkg::incsp_word_type exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      err_count++;
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // Held until taken; reply compared when the frame ends
  task automatic xfer(input incsp_pkg::incsp_word_type w,
    input incsp_pkg::incsp_word_type exp, input logic chk);
    int n;
    n = 0;
    req_word = w;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 6000)
    begin
      tick(1);
      n++;
    end
    tick(1);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 6000)
    begin
      tick(1);
      n++;
    end
    if (n >= 6000)
      err_count++;
    if (chk)
      check("rsp_word", rsp_word, exp);
  endtask : xfer

  // Hand-made frame of nb clocks on the second link
  task automatic bang(input incsp_pkg::incsp_word_type w, input int nb,
    input logic cs);
    u_incsp_link_if_b.cs_n = cs;
    u_incsp_link_if_b.sdi = w[15];
    tick(6);
    for (int i = 0; i < nb; i++)
    begin
      u_incsp_link_if_b.sclk = 1'b0;
      u_incsp_link_if_b.sdi = w[15-i];
      tick(4);
      u_incsp_link_if_b.sclk = 1'b1;
      tick(4);
    end
    u_incsp_link_if_b.cs_n = 1'b1;
    tick(20);
  endtask : bang

  // Mode change skips one spacing check
  always @(negedge u_incsp_link_if.cs_n)
  begin
    if (last_fall >= 0 && last_sts == sts)
      check("gap", {15'h0000, (cyc - last_fall) >=
        ((sts <= 8'h07) ? 400 : 1000)}, 16'h0001);
    last_fall = cyc;
    last_sts = sts;
  end

  initial
  begin
    u_incsp_link_if_b.cs_n = 1'b1;
    u_incsp_link_if_b.sclk = 1'b1;
    u_incsp_link_if_b.sdi = 1'b0;
    tick(8);
    nrst = 1'b1;
    tick(1);
    xfer(16'h0C00, 16'h0000, 1'b0);
    xfer(16'h0E00, reg_val(6'h0C), 1'b1);
    for (int i = 0; i < 5; i++)
      xfer({2'h2, 6'(i), 8'h30 + 8'(i)}, reg_val(6'h0E), 1'b1);
    tick(8);
    check("frame_err", {15'h0000, frame_err}, 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      check("wr_valid", {15'h0000, wr_valid}, 16'h0001);
      check("wr_cmd", {2'h0, wr_addr, wr_data},
        {2'h0, 6'(i), 8'h30 + 8'(i)});
      wr_ready = 1'b1;
      tick(1);
      wr_ready = 1'b0;
      tick(1);
    end
    check("wr_valid", {15'h0000, wr_valid}, 16'h0000);
    xfer(16'hC123, reg_val(6'h0E), 1'b1);
    xfer(16'h4123, reg_val(6'h0E), 1'b1);
    tick(8);
    check("refused", {9'h000, wr_valid, rd_addr}, 16'h000E);
    sts = 8'h08;
    xfer(16'h0300, reg_val(6'h0E), 1'b1);
    xfer(16'h3F00, reg_val(6'h03), 1'b1);
    xfer(16'h8000, reg_val(6'h3F), 1'b1);
    tick(8);
    check("pre_reset", {15'h0000, wr_valid}, 16'h0001);
    nrst = 1'b0;
    tick(2);
    check("reset", {8'h00, wr_valid, frame_err, rd_addr}, 16'h0000);
    nrst = 1'b1;
    tick(2);
    bang(16'h9555, 16, 1'b1);
    check("ignored", {15'h0000, wr_valid_b}, 16'h0000);
    bang(16'h9555, 5, 1'b0);
    check("short", {15'h0000, frame_err_b}, 16'h0001);
    bang(16'h955A, 16, 1'b0);
    check("after_short", {frame_err_b, wr_valid_b, wr_addr_b, wr_data_b},
      {2'h1, 6'h15, 8'h5A});
    give_verdict();
  end

  initial
  begin
    #(60000 * 100);
    err_count++;
    give_verdict();
  end
endmodule : inclinometer_spi_slave_port_tb
